//--- gpps_map.svh
// constants of the port and pin steering block
`ifndef GPPS_MAP_SVH
`define GPPS_MAP_SVH
`define GPPS_PORT_W     8
`define GPPS_RST_DIR    8'hFF
`define GPPS_RST_LAT    8'h00
`define GPPS_RST_ANA    8'hFF
`define GPPS_RST_APF    8'h00
// steer select bit positions in alt_function_ctrl_a
`define GPPS_SEL_SERIAL 7
`define GPPS_SEL_SDO    6
`define GPPS_SEL_SS     5
`define GPPS_SEL_TGATE  3
// steer select bit positions in alt_function_ctrl_b
`define GPPS_SEL_PWM    0
`define GPPS_SEL_CCP    1
// number of steered functions
`define GPPS_NFUNC      6
`endif

//--- gpps_pin_model.sv
// package pin model: driven pins follow the port, others the outside level
`timescale 1ns/1ps
module gpps_pin_model (
  // port side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // outside level and pins seen
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pin_in
);
  // each pin resolves to the port drive or the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

//--- gpps_pin_sync.sv
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module gpps_pin_sync
  import gpps_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // pins
  input  wire logic [7:0] pin_raw,
  output logic      [7:0] pin_sync
);
  logic [7:0] stage1;
  logic [7:0] next_stage1;
  logic [7:0] next_sync;

  // pass through two stages
  always_comb begin
    next_stage1 = pin_raw;
    next_sync   = stage1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      stage1   <= next_stage1;
      pin_sync <= next_sync;
    end
  end
endmodule

//--- gpps_pkg.sv
// types of the port and pin steering block
package gpps_pkg;
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] lat;
    logic [7:0] ana;
  } gpps_port_cfg_t;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpps_pin_drv_t;
  // one steerable peripheral function: value, drive, override enable
  typedef struct packed {
    logic val;
    logic drive;
    logic en;
  } gpps_func_t;
  typedef enum logic [1:0] {GPPS_IDLE, GPPS_SYNC} gpps_state_t;
endpackage

//--- gpps_port.sv
// general purpose port with analog select and alternate pin steering
// pin map of the steered functions, candidate pin when select is 0 / 1:
//   serial receive/data   pin 0 / pin 5
//   serial transmit/clock pin 1 / pin 4
//   serial data out one   pin 2 / pin 7
//   slave select          pin 3 / pin 5
//   enhanced pwm outputs  pin 4 / pin 6
//   capture/compare outs  pin 6 / pin 7
//   timer gate input      pin 4 / pin 3
//
// priority on a pin, highest first:
//   - a steered function that has chosen this pin, later index winning
//   - the plain per-pin peripheral enable
//   - the port itself: output latch and direction bit
//
// hazards a user must know:
//   - a pin shared by two steered functions goes to the later function;
//     software must not select both onto one pin
//   - the steered override brings its own drive enable, so the direction
//     bit of an overridden pin is ignored but never rewritten
//   - pin levels reach the read path three edges after they change,
//     because of the two synchroniser stages and the output register
//   - an analog-selected pin always reads zero, also on the steered
//     peripheral inputs, so an analog pin cannot feed a peripheral
`timescale 1ns/1ps
`include "gpps_map.svh"
module gpps_port
  import gpps_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // cpu register access strobes
  input  wire logic       wr_dir,
  input  wire logic       wr_lat,
  input  wire logic       wr_level,
  input  wire logic       wr_ana,
  input  wire logic       wr_apf_a,
  input  wire logic       wr_apf_b,
  input  wire logic [7:0] wr_data,
  // peripheral functions, fixed order serial_rx, serial_tx, sdo, ss, pwm, ccp
  input  wire gpps_func_t [5:0] periph_func,
  // extra plain peripheral enables per pin
  input  wire logic [7:0] periph_en,
  input  wire logic [7:0] periph_out,
  input  wire logic [7:0] periph_drive,
  // pins
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  // register read values
  output logic      [7:0] pin_direction_reg,
  output logic      [7:0] output_latch_reg,
  output logic      [7:0] pin_level_reg,
  output logic      [7:0] analog_select_reg,
  output logic      [7:0] alt_function_ctrl_a,
  output logic      [7:0] alt_function_ctrl_b,
  // steered peripheral inputs
  output logic            serial_receive_data,
  output logic            timer_gate_in,
  output logic            slave_select_in
);
  // ****************************************************
  // register state
  // ****************************************************
  logic [7:0] next_dir;
  logic [7:0] next_lat;
  logic [7:0] next_ana;
  logic [7:0] next_apf_a;
  logic [7:0] next_apf_b;
  logic [7:0] pin_sync;

  // every register has its own write strobe; simultaneous strobes each
  // land in their own register, so software can load several in one cycle.
  // the latch takes both the latch strobe and the pin level strobe, since
  // writing the pin level register really writes the latch.
  // the steering registers keep only the bits that exist; the rest read 0.
  // no steering write ever touches the direction register, which keeps
  // the software view of the direction stable across pin moves.
  //
  // direction written only by its own strobe
  always_comb begin
    next_dir   = wr_dir ? wr_data : pin_direction_reg;
    next_lat   = output_latch_reg;
    if (wr_lat || wr_level) begin
      next_lat = wr_data;
    end
    next_ana   = wr_ana ? wr_data : analog_select_reg;
    next_apf_a = alt_function_ctrl_a;
    next_apf_b = alt_function_ctrl_b;
    if (wr_apf_a) begin
      next_apf_a = wr_data & 8'hE8;
    end
    if (wr_apf_b) begin
      next_apf_b = wr_data & 8'h03;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_direction_reg   <= `GPPS_RST_DIR;
      output_latch_reg    <= `GPPS_RST_LAT;
      analog_select_reg   <= `GPPS_RST_ANA;
      alt_function_ctrl_a <= `GPPS_RST_APF;
      alt_function_ctrl_b <= `GPPS_RST_APF;
    end else begin
      pin_direction_reg   <= next_dir;
      output_latch_reg    <= next_lat;
      analog_select_reg   <= next_ana;
      alt_function_ctrl_a <= next_apf_a;
      alt_function_ctrl_b <= next_apf_b;
    end
  end

  // ****************************************************
  // pin input path
  // ****************************************************
  gpps_pin_sync u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_raw  (pin_in),
    .pin_sync (pin_sync)
  );

  // ****************************************************
  // steering of the six functions
  // ****************************************************
  // each function is split into two override candidates; the candidate
  // that the select bit does not choose carries no enable, so that pin
  // falls back to its normal port behaviour without any extra gating.
  // the serial pair shares one select bit, so receive and transmit always
  // move together and never end up split across the two pin groups.
  //
  // candidate pin pairs per function
  localparam int unsigned PIN0 [6] = '{0, 1, 2, 3, 4, 6};
  localparam int unsigned PIN1 [6] = '{5, 4, 7, 5, 6, 7};

  logic [5:0]       sel_vec;
  gpps_func_t [5:0] ovr0;
  gpps_func_t [5:0] ovr1;

  // select bit per function
  always_comb begin
    sel_vec[0] = alt_function_ctrl_a[`GPPS_SEL_SERIAL];
    sel_vec[1] = alt_function_ctrl_a[`GPPS_SEL_SERIAL];
    sel_vec[2] = alt_function_ctrl_a[`GPPS_SEL_SDO];
    sel_vec[3] = alt_function_ctrl_a[`GPPS_SEL_SS];
    sel_vec[4] = alt_function_ctrl_b[`GPPS_SEL_PWM];
    sel_vec[5] = alt_function_ctrl_b[`GPPS_SEL_CCP];
  end

  genvar g;
  generate
    for (g = 0; g < `GPPS_NFUNC; g = g + 1) begin : g_steer
      gpps_steer u_st (
        .func    (periph_func[g]),
        .sel     (sel_vec[g]),
        .to_pin0 (ovr0[g]),
        .to_pin1 (ovr1[g])
      );
    end
  endgenerate

  // ****************************************************
  // pin driver
  // ****************************************************
  logic [7:0] next_out;
  logic [7:0] next_oe;
  logic [7:0] next_level;
  logic [7:0] dig_in;
  logic       ovr_en;
  logic       ovr_val;
  logic       ovr_drv;

  // per pin: collect the winning override, else fall back to the port.
  // the drive is registered so every pin output comes from a flip-flop;
  // this adds one cycle between a register write and the pin reacting.
  // the level path reads the synchronised pins whatever drives them, so
  // a pin owned by a peripheral still shows its real level.
  always_comb begin
    next_out = 8'h00;
    next_oe  = 8'h00;
    ovr_en   = 1'b0;
    ovr_val  = 1'b0;
    ovr_drv  = 1'b0;
    for (int p = 0; p < 8; p++) begin
      ovr_en  = periph_en[p];
      ovr_val = periph_out[p];
      ovr_drv = periph_drive[p];
      // overrides land only on the chosen pin
      for (int f = 0; f < 6; f++) begin
        if (PIN0[f] == p && ovr0[f].en) begin
          ovr_en  = 1'b1;
          ovr_val = ovr0[f].val;
          ovr_drv = ovr0[f].drive;
        end
        if (PIN1[f] == p && ovr1[f].en) begin
          ovr_en  = 1'b1;
          ovr_val = ovr1[f].val;
          ovr_drv = ovr1[f].drive;
        end
      end
      if (ovr_en) begin
        next_out[p] = ovr_val;
        next_oe[p]  = ovr_drv;
      end else begin
        next_out[p] = output_latch_reg[p];
        next_oe[p]  = ~pin_direction_reg[p];
      end
    end
    dig_in     = pin_sync & ~analog_select_reg;
    next_level = dig_in;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out       <= 8'h00;
      pin_oe        <= 8'h00;
      pin_level_reg <= 8'h00;
    end else begin
      pin_out       <= next_out;
      pin_oe        <= next_oe;
      pin_level_reg <= next_level;
    end
  end

  // ****************************************************
  // steered peripheral inputs
  // ****************************************************
  logic next_rx;
  logic next_tg;
  logic next_ss;

  // pick the level of the chosen candidate pin
  function automatic logic pick_pin(
    input logic [7:0]  levels,
    input logic        sel,
    input int unsigned p0,
    input int unsigned p1
  );
    return sel ? levels[p1] : levels[p0];
  endfunction

  // read from whichever pin is selected
  // the unselected candidate is ignored, so its level never disturbs the
  // peripheral; the timer gate has its own pair outside the output table.
  always_comb begin
    next_rx = pick_pin(dig_in, alt_function_ctrl_a[`GPPS_SEL_SERIAL], PIN0[0], PIN1[0]);
    next_ss = pick_pin(dig_in, alt_function_ctrl_a[`GPPS_SEL_SS], PIN0[3], PIN1[3]);
    next_tg = pick_pin(dig_in, alt_function_ctrl_a[`GPPS_SEL_TGATE], 4, 3);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_receive_data <= 1'b0;
      timer_gate_in       <= 1'b0;
      slave_select_in     <= 1'b0;
    end else begin
      serial_receive_data <= next_rx;
      timer_gate_in       <= next_tg;
      slave_select_in     <= next_ss;
    end
  end
endmodule

//--- gpps_properties.sv
// concurrent checks of the port and pin steering block
`timescale 1ns/1ps
module gpps_properties
  import gpps_pkg::*;
(
  // clock and reset
  input wire logic             core_clk,
  input wire logic             rst_n,
  // inputs
  input wire logic             wr_dir,
  input wire logic             wr_lat,
  input wire logic             wr_apf_a,
  input wire logic [7:0]       wr_data,
  input wire gpps_func_t [5:0] periph_func,
  input wire logic [7:0]       periph_en,
  input wire logic [7:0]       periph_out,
  input wire logic [7:0]       periph_drive,
  input wire logic [7:0]       pin_in,
  // outputs
  input wire logic [7:0]       pin_out,
  input wire logic [7:0]       pin_oe,
  input wire logic [7:0]       pin_direction_reg,
  input wire logic [7:0]       output_latch_reg,
  input wire logic [7:0]       pin_level_reg,
  input wire logic [7:0]       analog_select_reg,
  input wire logic [7:0]       alt_function_ctrl_a,
  input wire logic [7:0]       alt_function_ctrl_b
);
  logic       fo;
  logic       fo_q;
  logic [7:0] next_oe;
  logic [7:0] next_out;
  logic [7:0] oe_q;
  logic [7:0] out_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // expected plain port drive when no steered override is active
  always_comb begin
    fo = ((periph_func & 18'h0_9249) == 18'h0_0000);
    next_oe = (periph_en & periph_drive) | (~periph_en & ~pin_direction_reg);
    next_out = (periph_en & periph_out) | (~periph_en & output_latch_reg);
  end
  // expectation registered to the pin drive latency
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) {fo_q, oe_q, out_q} <= '0;
    else {fo_q, oe_q, out_q} <= {fo, next_oe, next_out};
  end
  chk_lat_write:
    assert property (wr_lat |=> output_latch_reg == $past(wr_data)) else $error("latch write lost");
  chk_dir_write:
    assert property (wr_dir |=> pin_direction_reg == $past(wr_data)) else $error("direction write lost");
  chk_dir_hold:
    assert property (!wr_dir |=> $stable(pin_direction_reg)) else $error("direction changed");
  chk_apf_write:
    assert property (wr_apf_a |=> alt_function_ctrl_a == ($past(wr_data) & 8'hE8)) else $error("steer write bad");
  chk_port_oe:
    assert property (fo_q |-> pin_oe == oe_q) else $error("pin enable bad");
  chk_port_out:
    assert property (fo_q |-> ((pin_out ^ out_q) & pin_oe) == 8'h00) else $error("pin value bad");
  chk_level_read:
    assert property ($stable(analog_select_reg) [*4] |-> pin_level_reg == ($past(pin_in, 3) & ~analog_select_reg))
      else $error("pin level bad");
  chk_pwm_steer:
    assert property ($past(periph_func[4].en) && !$past(periph_func[5].en) && $past(alt_function_ctrl_b[0])
      |-> pin_oe[6] == $past(periph_func[4].drive)) else $error("steered drive bad");
endmodule
bind gpps_port gpps_properties u_chk (.core_clk, .rst_n, .wr_dir, .wr_lat, .wr_apf_a, .wr_data, .periph_func,
  .periph_en, .periph_out, .periph_drive, .pin_in, .pin_out, .pin_oe, .pin_direction_reg, .output_latch_reg,
  .pin_level_reg, .analog_select_reg, .alt_function_ctrl_a, .alt_function_ctrl_b);

//--- gpps_steer.sv
// steering of one peripheral function to one of two pins
`timescale 1ns/1ps
module gpps_steer
  import gpps_pkg::*;
(
  // function and select
  input  wire gpps_func_t func,
  input  wire logic       sel,
  // per-candidate override outputs
  output gpps_func_t      to_pin0,
  output gpps_func_t      to_pin1
);
  // unselected candidate sees no override
  always_comb begin
    to_pin0 = sel ? '0 : func;
    to_pin1 = sel ? func : '0;
  end
endmodule

//--- test_gpio_port_with_pin_steering.sv
// self-checking bench of the port and pin steering block
`timescale 1ns/1ps
module test_gpio_port_with_pin_steering
  import gpps_pkg::*;
;
  logic             core_clk = 0;
  logic             rst_n = 0;
  logic [5:0]       st = '0;
  logic [7:0]       wd = '0, pe = '0, po = '0, pd = '0, ext = '0;
  logic [7:0]       pin_in, pin_out, pin_oe, dir, lat, lvl, ana, apa, apb;
  logic             srx, tg, ssi;
  gpps_func_t [5:0] pf = '0;
  int               fails = 0, checked = 0, cycles = 0;
  gpps_port dut (.core_clk, .rst_n, .wr_dir(st[0]), .wr_lat(st[1]), .wr_level(st[2]), .wr_ana(st[3]),
    .wr_apf_a(st[4]), .wr_apf_b(st[5]), .wr_data(wd), .periph_func(pf), .periph_en(pe), .periph_out(po),
    .periph_drive(pd), .pin_in, .pin_out, .pin_oe, .pin_direction_reg(dir), .output_latch_reg(lat),
    .pin_level_reg(lvl), .analog_select_reg(ana), .alt_function_ctrl_a(apa), .alt_function_ctrl_b(apb),
    .serial_receive_data(srx), .timer_gate_in(tg), .slave_select_in(ssi));
  gpps_pin_model pins (.pin_out, .pin_oe, .ext_level(ext), .pin_in);
  // clock and hang limit
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      complete_run();
    end
  end
  task automatic cyc(int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // strobe stays up until the caller lowers it
  task automatic wr(int k, logic [7:0] d);
    st = 6'h01 << k;
    wd = d;
    cyc();
  endtask
  task automatic complete_run();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_regs();
    check(dir, 8'hFF);
    check(lat, 8'h00);
    wr(0, 8'h38);
    check(dir, 8'h38);
    wr(1, 8'h55);
    check(lat, 8'h55);
    wr(2, 8'hA6);
    st = '0;
    check(lat, 8'hA6);
    cyc();
    check(pin_oe, 8'hC7);
    check(pin_out & 8'hC7, 8'h86);
  endtask
  task automatic t_level();
    ext = 8'h3C;
    wr(3, 8'hF0);
    st = '0;
    check(ana, 8'hF0);
    cyc(4);
    check(lvl, 8'h0E);
    pe = 8'h01;
    po = 8'h01;
    pd = 8'h01;
    wr(3, 8'h00);
    st = '0;
    cyc(4);
    check(pin_out & 8'hC7, 8'h87);
    check(lvl, 8'hBF);
    pe = '0;
  endtask
  task automatic t_steer();
    wr(0, 8'hFF);
    wr(5, 8'hFF);
    check(apb, 8'h03);
    wr(4, 8'hFF);
    st = '0;
    check(apa, 8'hE8);
    check(dir, 8'hFF);
    pf[4] = 3'h7;
    cyc(2);
    check(pin_oe, 8'h40);
    check(pin_out & 8'h40, 8'h40);
    wr(5, 8'h02);
    st = '0;
    ext = 8'h28;
    cyc(4);
    check(pin_oe, 8'h10);
    check({5'h00, srx, tg, ssi}, 8'h07);
    ext = 8'h01;
    cyc(4);
    check({5'h00, srx, tg, ssi}, 8'h00);
  endtask
  // reset, scenarios, verdict
  initial begin
    cyc(12);
    rst_n = 1;
    cyc();
    t_regs();
    t_level();
    t_steer();
    complete_run();
  end
endmodule
